// ==== hw/sepw_pkg.sv ====
// Package: constants and types for the serial EEPROM power and write control block
//
// Overview of operation
// - Enter standby when supply is good; fall back to reset when it drops.
// - Leaving reset, the write-enable latch is clear and the device idles in standby.
// - Instructions accepted only after a falling chip select following power-up.
// - Completed byte, page or status write clears the write-enable latch.
// - Internal write starts only on the rising chip select ending a write.
// - Array access during an internal write is ignored; programming continues.
// - Undefined opcode ignored, data output stays high impedance until deselect.
// - Write-enable instruction then chip select high sets the latch and status copy.
// - Write-disable instruction clears the write-enable latch.
// - During an internal write only read-status is obeyed.
// - Status bit 0 is high while an internal write runs, low when ready.
package sepw_pkg;

    // ---------------------------------------------------------------
    // Instruction codes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_WRSR    = 8'h01;
    localparam logic [7:0] OP_WRITE   = 8'h02;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_WR_DIS  = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_EN   = 8'h06;

    // ---------------------------------------------------------------
    // Status register layout
    // ---------------------------------------------------------------
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_LATCH_BIT = 1;
    localparam logic [7:0]  ST_WR_MASK  = 8'h8c;
    localparam logic [7:0]  ST_RESET    = 8'h00;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int          CLK_HZ        = 50000000;
    localparam int          WRITE_TIME_US = 5;
    localparam int          WRITE_CYCLES  = (WRITE_TIME_US * (CLK_HZ / 1000000));
    localparam int          BIT_CNT_W     = 6;
    localparam logic [5:0]  OP_BITS       = 6'h08;
    localparam logic [5:0]  WR_MIN_BITS   = 6'h20;
    localparam logic [5:0]  SR_WR_BITS    = 6'h10;

    typedef enum logic [2:0] {
        ST_RESET_MODE = 3'b000,
        ST_STANDBY    = 3'b001,
        ST_READY      = 3'b010,
        ST_OPCODE     = 3'b011,
        ST_ACTIVE     = 3'b100,
        ST_IGNORE     = 3'b101
    } sepw_state_type;

    typedef enum logic [1:0] {
        WK_NONE = 2'b00,
        WK_ARR  = 2'b01,
        WK_SR   = 2'b10
    } sepw_wkind_type;

    // Synchronised link pins and their edges
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic cs_fall;
        logic cs_rise;
        logic sck_rise;
        logic sck_fall;
    } sepw_link_type;

endpackage

// ==== hw/sepw_sync.sv ====
// Two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/1ns
`default_nettype none
module sepw_sync (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sck_i,
    input  wire logic                   si_i,
    output sepw_pkg::sepw_link_type     link_o
);
    logic [2:0] meta_q;
    logic [2:0] meta_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic [2:0] prev_q;
    logic [2:0] prev_d;

    always_comb begin
        meta_d = {cs_n_i, sck_i, si_i};
        sync_d = meta_q;
        prev_d = sync_q;
        link_o.cs_n     = sync_q[2];
        link_o.sck      = sync_q[1];
        link_o.si       = sync_q[0];
        link_o.cs_fall  = prev_q[2] & ~sync_q[2];
        link_o.cs_rise  = ~prev_q[2] & sync_q[2];
        link_o.sck_rise = ~prev_q[1] & sync_q[1];
        link_o.sck_fall = prev_q[1] & ~sync_q[1];
    end

    // Idle levels at reset (select high, clock low) keep false edges away
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 3'h4;
            sync_q <= 3'h4;
            prev_q <= 3'h4;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end
endmodule
`default_nettype wire

// ==== hw/sepw_ctrl.sv ====
// Serial EEPROM power state, write-enable latch and internal write control
`timescale 1ns/1ns
`default_nettype none
module sepw_ctrl #(
    parameter int WRITE_CYCLES = sepw_pkg::WRITE_CYCLES
) (
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        SUPPLY_OK_I,
    input  wire logic        CS_N_I,
    input  wire logic        SCK_I,
    input  wire logic        SI_I,
    output logic             SO_O,
    output logic             SO_OE_N_O,
    output logic             STANDBY_O,
    output logic             WRITE_ENABLE_LATCH_O,
    output logic             WRITE_BUSY_O,
    output logic             ARRAY_WRITE_START_O,
    output logic [7:0]       STATUS_O
);
    // Write timer is twenty bits wide
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 1048575) begin : g_bad_write_cycles
        $error("WRITE_CYCLES out of range");
    end

    sepw_pkg::sepw_link_type link;

    logic        sup_meta_q;
    logic        sup_q;

    sepw_sync u_sepw_sync (
        .clk_i  (CLK_I),
        .rst_i  (SYS_RST_I),
        .cs_n_i (CS_N_I),
        .sck_i  (SCK_I),
        .si_i   (SI_I),
        .link_o (link)
    );

    // ---------------------------------------------------------------
    // Supply-good synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sup_meta_q <= 1'b0;
            sup_q      <= 1'b0;
        end else begin
            sup_meta_q <= SUPPLY_OK_I;
            sup_q      <= sup_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Protocol state
    // ---------------------------------------------------------------
    sepw_pkg::sepw_state_type state_q, state_d;
    sepw_pkg::sepw_wkind_type wkind_q, wkind_d;
    logic [7:0]  op_q, op_d;
    logic [5:0]  bits_q, bits_d;
    logic [7:0]  sr_q, sr_d;
    logic [7:0]  sr_new_q, sr_new_d;
    logic [7:0]  tx_q, tx_d;
    logic        so_q, so_d;
    logic        so_oe_n_q, so_oe_n_d;
    logic        latch_q, latch_d;
    logic        busy_q, busy_d;
    logic        start_q, start_d;
    logic [19:0] wcnt_q, wcnt_d;

    always_comb begin
        state_d   = state_q;
        wkind_d   = wkind_q;
        op_d      = op_q;
        bits_d    = bits_q;
        sr_d      = sr_q;
        sr_new_d  = sr_new_q;
        tx_d      = tx_q;
        so_d      = so_q;
        so_oe_n_d = so_oe_n_q;
        latch_d   = latch_q;
        busy_d    = busy_q;
        start_d   = 1'b0;
        wcnt_d    = wcnt_q;

        // Internal write timer runs regardless of bus activity
        if (busy_q) begin
            if (wcnt_q == 20'h00000) begin
                busy_d = 1'b0;
                latch_d = 1'b0;
                if (wkind_q == sepw_pkg::WK_SR) begin
                    sr_d = (sr_q & ~sepw_pkg::ST_WR_MASK) | (sr_new_q & sepw_pkg::ST_WR_MASK);
                end
                wkind_d = sepw_pkg::WK_NONE;
            end else begin
                wcnt_d = wcnt_q - 20'h00001;
            end
        end

        if (!sup_q) begin
            // Brown-out: abandon everything, output off
            state_d   = sepw_pkg::ST_RESET_MODE;
            so_oe_n_d = 1'b1;
            latch_d   = 1'b0;
            busy_d    = 1'b0;
            wkind_d   = sepw_pkg::WK_NONE;
        end else begin
            unique case (state_q)
                sepw_pkg::ST_RESET_MODE: begin
                    state_d = sepw_pkg::ST_STANDBY;
                    latch_d = 1'b0;
                end
                sepw_pkg::ST_STANDBY: begin
                    // Only a falling select arms the device after power-up
                    if (link.cs_fall) begin
                        state_d = sepw_pkg::ST_OPCODE;
                        bits_d  = '0;
                    end
                end
                sepw_pkg::ST_READY: begin
                    if (link.cs_fall) begin
                        state_d = sepw_pkg::ST_OPCODE;
                        bits_d  = '0;
                    end
                end
                sepw_pkg::ST_OPCODE, sepw_pkg::ST_ACTIVE, sepw_pkg::ST_IGNORE: begin
                    if (link.cs_rise) begin
                        state_d   = sepw_pkg::ST_READY;
                        so_oe_n_d = 1'b1;
                        if (state_q == sepw_pkg::ST_ACTIVE && !busy_q) begin
                            if (op_q == sepw_pkg::OP_WR_EN && bits_q == sepw_pkg::OP_BITS) begin
                                latch_d = 1'b1;
                            end
                            if (op_q == sepw_pkg::OP_WRITE && latch_q && bits_q >= sepw_pkg::WR_MIN_BITS
                                && bits_q[2:0] == 3'h0) begin
                                busy_d  = 1'b1;
                                start_d = 1'b1;
                                wkind_d = sepw_pkg::WK_ARR;
                                wcnt_d  = 20'(WRITE_CYCLES - 1);
                            end
                            if (op_q == sepw_pkg::OP_WRSR && latch_q && bits_q == sepw_pkg::SR_WR_BITS) begin
                                busy_d  = 1'b1;
                                wkind_d = sepw_pkg::WK_SR;
                                wcnt_d  = 20'(WRITE_CYCLES - 1);
                            end
                        end
                    end else if (link.sck_rise && state_q != sepw_pkg::ST_IGNORE) begin
                        if (bits_q == 6'h3f) begin
                            // Full count wraps but keeps the byte phase, so long page writes pass
                            bits_d = 6'h38;
                        end else begin
                            bits_d = bits_q + 6'h01;
                        end
                        if (state_q == sepw_pkg::ST_OPCODE) begin
                            op_d = {op_q[6:0], link.si};
                            if (bits_q == sepw_pkg::OP_BITS - 6'h01) begin
                                state_d = sepw_pkg::ST_ACTIVE;
                                unique case ({op_q[6:0], link.si})
                                    sepw_pkg::OP_RD_STAT: begin
                                        tx_d = {sr_q[7:2], latch_q, busy_q};
                                    end
                                    sepw_pkg::OP_WR_DIS: begin
                                        if (!busy_q) begin
                                            latch_d = 1'b0;
                                        end else begin
                                            state_d = sepw_pkg::ST_IGNORE;
                                        end
                                    end
                                    sepw_pkg::OP_WR_EN, sepw_pkg::OP_WRITE, sepw_pkg::OP_WRSR,
                                    sepw_pkg::OP_READ: begin
                                        if (busy_q) begin
                                            state_d = sepw_pkg::ST_IGNORE;
                                        end
                                    end
                                    default: begin
                                        state_d = sepw_pkg::ST_IGNORE;
                                    end
                                endcase
                            end
                        end else if (op_q == sepw_pkg::OP_WRSR && bits_q < sepw_pkg::SR_WR_BITS) begin
                            sr_new_d = {sr_new_q[6:0], link.si};
                        end
                    end else if (link.sck_fall && state_q == sepw_pkg::ST_ACTIVE
                                 && op_q == sepw_pkg::OP_RD_STAT) begin
                        // Status repeats every eight clocks while selected
                        so_oe_n_d = 1'b0;
                        so_d      = tx_q[7];
                        tx_d      = {tx_q[6:0], tx_q[7]};
                    end
                end
                default: begin
                    state_d = sepw_pkg::ST_RESET_MODE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_q   <= sepw_pkg::ST_RESET_MODE;
            wkind_q   <= sepw_pkg::WK_NONE;
            op_q      <= 8'h00;
            bits_q    <= 6'h00;
            sr_q      <= sepw_pkg::ST_RESET;
            sr_new_q  <= 8'h00;
            tx_q      <= 8'h00;
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
            latch_q   <= 1'b0;
            busy_q    <= 1'b0;
            start_q   <= 1'b0;
            wcnt_q    <= 20'h00000;
        end else begin
            state_q   <= state_d;
            wkind_q   <= wkind_d;
            op_q      <= op_d;
            bits_q    <= bits_d;
            sr_q      <= sr_d;
            sr_new_q  <= sr_new_d;
            tx_q      <= tx_d;
            so_q      <= so_d;
            so_oe_n_q <= so_oe_n_d;
            latch_q   <= latch_d;
            busy_q    <= busy_d;
            start_q   <= start_d;
            wcnt_q    <= wcnt_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    logic stby_q;
    logic [7:0] status_q;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            stby_q   <= 1'b0;
            status_q <= 8'h00;
        end else begin
            stby_q   <= (state_d == sepw_pkg::ST_STANDBY);
            status_q <= {sr_d[7:2], latch_d, busy_d};
        end
    end
    assign SO_O                 = so_q;
    assign SO_OE_N_O            = so_oe_n_q;
    assign STANDBY_O            = stby_q;
    assign WRITE_ENABLE_LATCH_O = latch_q;
    assign WRITE_BUSY_O         = busy_q;
    assign ARRAY_WRITE_START_O  = start_q;
    assign STATUS_O             = status_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_brownout_reset: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !sup_q |=> state_q == sepw_pkg::ST_RESET_MODE) else $error("no reset mode on low supply");
    a_reset_latch_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state_q == sepw_pkg::ST_RESET_MODE |-> !latch_q) else $error("latch set in reset mode");
    a_select_first: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state_q == sepw_pkg::ST_STANDBY && !link.cs_fall |=> state_q != sepw_pkg::ST_OPCODE)
        else $error("opcode without falling select");
    a_write_done_latch: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        $fell(busy_q) |-> !latch_q) else $error("latch kept after write");
    a_start_on_rise: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(busy_q) |-> $past(link.cs_rise) && $past(latch_q)) else $error("write not on rising select");
    a_busy_holds: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        busy_q && wcnt_q != 20'h00000 && sup_q |=> busy_q) else $error("write interrupted");
    a_busy_latch_kept: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        busy_q && latch_q && sup_q && wcnt_q != 20'h00000 |=> latch_q) else $error("latch changed during write");
    a_bad_op_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state_q == sepw_pkg::ST_IGNORE |-> so_oe_n_q) else $error("output driven on ignored op");
    a_latch_sets: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(latch_q) |-> $past(op_q) == sepw_pkg::OP_WR_EN && $past(link.cs_rise))
        else $error("latch set without write-enable");
    a_status_busy: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        ##1 STATUS_O[sepw_pkg::ST_BUSY_BIT] == busy_q) else $error("busy bit mismatch");
    a_reset_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state_q == sepw_pkg::ST_RESET_MODE |-> so_oe_n_q) else $error("output driven in reset mode");
endmodule
`default_nettype wire

// ==== verif/sepw_host.sv ====
// Host serial bus controller model driving the link pins in mode 0
`timescale 1ns/1ns
`default_nettype none
module sepw_host (
    input  wire logic clk_i,
    input  wire logic so_i,
    input  wire logic so_oe_n_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    logic [7:0] rd_q;
    logic       oe_seen_q;

    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        rd_q = 8'h00;
        oe_seen_q = 1'b0;
    end

    // Falling select opens every frame
    task automatic sel();
        @(negedge clk_i);
        cs_n_o = 1'b0;
        oe_seen_q = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    // Select rises only after the whole count of bits
    task automatic desel();
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // Released data line must not keep its last value
        si_o = ~si_o;
        repeat (8) @(negedge clk_i);
    endtask

    // Msb first; output sampled late in the high phase, well after it moves
    task automatic shift(input logic [39:0] b, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            si_o = b[i];
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
            rd_q = {rd_q[6:0], so_i};
            if (so_oe_n_i === 1'b0) begin
                oe_seen_q = 1'b1;
            end
            sck_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/test_serial_eeprom_power_write_control.sv ====
// Testbench for the serial EEPROM power and write control block
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_power_write_control;
    localparam int         WCYC   = 1000;
    localparam logic [7:0] BAD[3] = '{8'h00, 8'h07, 8'hff};
    logic       clk;
    logic       rst;
    logic       sup;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       so;
    logic       oe_n;
    logic       stby;
    logic       latch;
    logic       busy;
    logic       wstart;
    logic [7:0] stat;
    logic [7:0] lf;
    logic [7:0] exp_q[$];
    int         num_errors;
    int         check_count;
    int         starts;

    sepw_ctrl #(.WRITE_CYCLES(WCYC)) u_sepw_ctrl (
        .CLK_I(clk), .SYS_RST_I(rst), .SUPPLY_OK_I(sup),
        .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .SO_O(so), .SO_OE_N_O(oe_n),
        .STANDBY_O(stby), .WRITE_ENABLE_LATCH_O(latch), .WRITE_BUSY_O(busy),
        .ARRAY_WRITE_START_O(wstart), .STATUS_O(stat));

    sepw_host u_sepw_host (
        .clk_i(clk), .so_i(so), .so_oe_n_i(oe_n),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    always #10 clk = ~clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
        check_count++;
        if (seen !== ex) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Which: 0 standby flag, 1 busy flag
    task automatic wait_for(input int which, input logic v, input int lim);
        int n;
        n = 0;
        while (((which == 0) ? stby : busy) !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                num_errors++;
                $display("wrong value wait %0d expected %b seen timeout", which, v);
                end_sim();
            end
        end
    endtask

    task automatic frame(input logic [39:0] b, input int n);
        u_sepw_host.sel();
        u_sepw_host.shift(b, n);
        u_sepw_host.desel();
    endtask

    // ----------------------------------------
    // Watcher: each finished write pops one note
    // ----------------------------------------
    initial begin : watch
        logic prev;
        prev = 1'b0;
        forever begin
            @(negedge clk);
            if (wstart === 1'b1) begin
                starts++;
            end
            if (prev === 1'b1 && busy === 1'b0) begin
                repeat (2) @(negedge clk);
                if (exp_q.size() == 0) begin
                    chk("unexpected write end", 8'h01, 8'h00);
                end else begin
                    chk("status after write", stat, exp_q.pop_front());
                end
            end
            prev = busy;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sup = 1'b1;
        lf = 8'h24;
        num_errors = 0;
        check_count = 0;
        starts = 0;
        repeat (5) @(negedge clk);
        chk("oe_n in reset", {7'h0, oe_n}, 8'h01);
        rst = 1'b0;
        wait_for(0, 1'b1, 50);
        chk("latch after reset", {7'h0, latch}, 8'h00);
        lf = nxt(lf);
        // Write without enabling first must be refused
        frame({8'h00, 8'h02, 8'h00, lf, ~lf}, 32);
        chk("busy without latch", {7'h0, busy}, 8'h00);
        frame({32'h0, 8'h06}, 8);
        chk("latch set", {7'h0, latch}, 8'h01);
        chk("status latch bit", {7'h0, stat[1]}, 8'h01);
        frame({32'h0, 8'h04}, 8);
        chk("latch cleared", {7'h0, latch}, 8'h00);
        frame({32'h0, 8'h06}, 8);
        exp_q.push_back(8'h00);
        lf = nxt(lf);
        frame({8'h00, 8'h02, 4'h0, lf[3:0], lf, ~lf}, 32);
        chk("busy after write", {7'h0, busy}, 8'h01);
        chk("status busy bit", {7'h0, stat[0]}, 8'h01);
        frame({32'h0, 8'h04}, 8);
        chk("latch while busy", {7'h0, latch}, 8'h01);
        frame({8'h00, 8'h02, 8'h01, lf, lf}, 32);
        frame({8'h00, 8'h03, 8'h00, lf, 8'h00}, 32);
        chk("oe on read while busy", {7'h0, u_sepw_host.oe_seen_q}, 8'h00);
        frame({24'h0, 8'h05, 8'h00}, 16);
        chk("status read busy", u_sepw_host.rd_q, 8'h03);
        wait_for(1, 1'b0, WCYC + 50);
        repeat (4) @(negedge clk);
        chk("write starts", starts[7:0], 8'h01);
        chk("latch after write", {7'h0, latch}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            frame({24'h0, BAD[i], 8'h00}, 16);
            chk("oe on bad code", {7'h0, u_sepw_host.oe_seen_q}, 8'h00);
        end
        frame({24'h0, 8'h05, 8'h00}, 16);
        chk("status read idle", u_sepw_host.rd_q, 8'h00);
        // Brown-out: bus must be ignored until the supply returns
        sup = 1'b0;
        wait_for(0, 1'b0, 50);
        frame({32'h0, 8'h06}, 8);
        frame({24'h0, 8'h05, 8'h00}, 16);
        chk("oe in reset mode", {7'h0, u_sepw_host.oe_seen_q}, 8'h00);
        chk("latch in reset mode", {7'h0, latch}, 8'h00);
        // Select already low at power-up: no falling edge seen
        u_sepw_host.sel();
        sup = 1'b1;
        repeat (20) @(negedge clk);
        u_sepw_host.shift({32'h0, 8'h06}, 8);
        u_sepw_host.desel();
        chk("latch without fall", {7'h0, latch}, 8'h00);
        wait_for(0, 1'b1, 50);
        frame({32'h0, 8'h06}, 8);
        chk("latch after fall", {7'h0, latch}, 8'h01);
        lf = nxt(lf);
        exp_q.push_back(lf & sepw_pkg::ST_WR_MASK);
        frame({24'h0, 8'h01, lf}, 16);
        chk("busy status write", {7'h0, busy}, 8'h01);
        wait_for(1, 1'b0, WCYC + 50);
        repeat (4) @(negedge clk);
        chk("notes left", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
